// ===== hdl/crex_consts.vh
`ifndef CREX_CONSTS_VH
`define CREX_CONSTS_VH

// ****************************************
// Event codes
// ****************************************
`define EC_POWERON 12'h000
`define EC_MANUAL 12'h020
`define EC_TLB_RD 12'h040
`define EC_TLB_WR 12'h060
`define EC_INIT_WR 12'h080
`define EC_PROT_RD 12'h0a0
`define EC_PROT_WR 12'h0c0
`define EC_ADDR_RD 12'h0e0
`define EC_ADDR_WR 12'h1e0
`define EC_TRAP 12'h160
`define EC_ILL_GEN 12'h180
`define EC_ILL_SLOT 12'h1a0
`define EC_BREAK 12'h1e0
`define EC_DMA 12'h5c0

// ****************************************
// Vectors and address checks
// ****************************************
`define RESET_VECTOR 32'ha0000000
`define VEC_GENERAL 32'h00000100
`define VEC_TLB_MISS 32'h00000400
`define USER_LIMIT_BIT 31
`define UNDEF_BASE 16'hf000

// ****************************************
// Access sizes and trap immediate layout
// ****************************************
`define SZ_BYTE 2'h0
`define SZ_WORD 2'h1
`define SZ_LONG 2'h2
`define TRA_HI_ZERO 22'h000000
`define TRA_LO_ZERO 2'h0
`define ZERO32 32'h00000000

`endif

// ===== hdl/crex_exception_unit.v
// How it works
// - Power-on reset sets event code 000 and redirects fetch to the reset vector.
// - Manual reset sets event code 020 and redirects fetch to the same vector.
// - Odd fetch, unaligned word or unaligned longword access raises an address error.
// - User-mode access at or above 80000000 raises an address error.
// - Address error records 0E0 on read and 1E0 on write.
// - Address and translation faults load the full fault address; translation updates MMU.
// - Fetch faults save fetch address; data faults save instruction or branch address.
// - Undefined or user-mode privileged code outside a slot gives code 180.
// - Control load/store, return, table load, sleep are privileged, except global-base access.
// - Undefined codes F000 to FFFF are always caught; others rely on the decoder.
// - Slot holding undefined, user privileged or PC-rewriting code gives code 1A0.
// - Illegal slot saves the owning delayed branch address.
// - Software trap records 160, saves next address, puts imm8 times four in bits 9:2.
// - Breakpoints record 1E0; pre-execution and async breaks re-execute, operand breaks complete.
// - Completion breaks save next address, re-execution the breaking one; slots use branch.
// - A DMA misalignment signal raises re-execution-type exception 5C0 independent of flow.
// - With translation on, check address error then miss, invalid, protection, initial write.
// - Table miss vectors to base plus 400 with 040 read, 060 write.
// - Hit on invalid entry records 040 read, 060 write.
// - Protection violation records 0A0 read, 0C0 write.
// - Store hitting a clean entry records 080.
// - Return slot: fetch faults use old status, others restored status; no breaks.
// - Status load that changes mode or mask bits forces a refetch of following code.
// - One exception accepted per cycle; pending ones wait in priority order.
// - Every general exception but table miss vectors to base plus 100.
`timescale 1ns/1ps
`default_nettype none
`include "crex_consts.vh"

module crex_exception_unit (
  input wire CLK_SYS,
  input wire NRST,
  input wire MRST_REQ,
  input wire [31:0] VECTOR_BASE,
  input wire STATUS_MD,
  input wire STATUS_BL,
  input wire SAVED_MD,
  input wire SAVED_BL,
  input wire MMU_EN,
  input wire ISSUE_VALID,
  input wire [31:0] ISSUE_PC,
  input wire [31:0] ISSUE_NEXT_PC,
  input wire [31:0] ISSUE_BRANCH_PC,
  input wire ISSUE_IN_SLOT,
  input wire [15:0] ISSUE_OP,
  input wire ISSUE_UNDEF,
  input wire ISSUE_CTRL_LS,
  input wire ISSUE_GLOBAL_BASE,
  input wire ISSUE_RTE,
  input wire ISSUE_TBL_LOAD,
  input wire ISSUE_SLEEP,
  input wire ISSUE_PC_WRITE,
  input wire ISSUE_TRAP,
  input wire [7:0] ISSUE_IMM8,
  input wire ISSUE_SR_LOAD,
  input wire ISSUE_SR_CHANGE,
  input wire FETCH_VALID,
  input wire [31:0] FETCH_ADDR,
  input wire FETCH_TLB_MISS,
  input wire FETCH_TLB_INVALID,
  input wire FETCH_TLB_PROT,
  input wire DATA_VALID,
  input wire [31:0] DATA_ADDR,
  input wire DATA_WRITE,
  input wire [1:0] DATA_SIZE,
  input wire DATA_TLB_MISS,
  input wire DATA_TLB_INVALID,
  input wire DATA_TLB_PROT,
  input wire DATA_TLB_CLEAN,
  input wire BRK_PRE,
  input wire BRK_OPERAND,
  input wire BRK_ASYNC,
  input wire DMA_ADDR_ERR,
  output reg EXC_TAKEN,
  output reg [31:0] EXC_TARGET,
  output reg [11:0] EVENT_CODE,
  output reg [31:0] SAVED_PC,
  output reg [31:0] FAULT_ADDR,
  output reg [31:0] IMM_SAVE,
  output reg MMU_UPDATE,
  output reg REFETCH,
  output reg PERIPH_INIT
);

  // ****************************************
  // Helpers
  // ****************************************
  function addr_err;
    input [31:0] addr;
    input [1:0] size;
    input user;
    begin
      addr_err = (user & addr[`USER_LIMIT_BIT])
        | ((size == `SZ_WORD) & addr[0])
        | ((size == `SZ_LONG) & (addr[1:0] != 2'h0));
    end
  endfunction

  function [11:0] rw_code;
    input wr;
    input [11:0] rd_code;
    input [11:0] wr_code;
    begin
      rw_code = wr ? wr_code : rd_code;
    end
  endfunction

  // ****************************************
  // State
  // ****************************************
  reg rte_q;
  reg abrk_q;
  reg dma_q;
  reg take_d;
  reg [11:0] code_d;
  reg [31:0] spc_d;
  reg [31:0] tea_d;
  reg [31:0] tra_d;
  reg [31:0] vec_d;
  reg mmu_d;
  reg refetch_d;
  reg clr_abrk;
  reg clr_dma;

  // Return slot: fetch already happened under the old status, the rest sees the restored one
  wire rte_slot = ISSUE_IN_SLOT & rte_q;
  wire data_md = rte_slot ? SAVED_MD : STATUS_MD;
  wire data_bl = rte_slot ? SAVED_BL : STATUS_BL;
  wire [31:0] slot_pc = ISSUE_IN_SLOT ? ISSUE_BRANCH_PC : ISSUE_PC;

  wire f_ae = FETCH_VALID & addr_err(FETCH_ADDR, `SZ_WORD, ~STATUS_MD);
  wire f_miss = FETCH_VALID & MMU_EN & FETCH_TLB_MISS;
  wire f_inv = FETCH_VALID & MMU_EN & FETCH_TLB_INVALID;
  wire f_prot = FETCH_VALID & MMU_EN & FETCH_TLB_PROT;

  // The decoder flag covers codes outside the guaranteed range on a best-effort basis
  wire undef = ISSUE_UNDEF | (ISSUE_OP >= `UNDEF_BASE);
  wire priv = (ISSUE_CTRL_LS & ~ISSUE_GLOBAL_BASE) | ISSUE_RTE | ISSUE_TBL_LOAD | ISSUE_SLEEP;
  wire priv_fault = priv & ~data_md;

  wire d_ae = DATA_VALID & addr_err(DATA_ADDR, DATA_SIZE, ~data_md);
  wire d_miss = DATA_VALID & MMU_EN & DATA_TLB_MISS;
  wire d_inv = DATA_VALID & MMU_EN & DATA_TLB_INVALID;
  wire d_prot = DATA_VALID & MMU_EN & DATA_TLB_PROT;
  wire d_clean = DATA_VALID & MMU_EN & DATA_WRITE & DATA_TLB_CLEAN;

  // Pre and operand breaks are dropped in a return slot and while exceptions are masked; a latched async break waits
  wire brk_ok = ~rte_slot & ~data_bl;

  // ****************************************
  // Priority selection
  // ****************************************
  always @*
  begin
    take_d = 1'b0;
    code_d = EVENT_CODE;
    spc_d = SAVED_PC;
    tea_d = FAULT_ADDR;
    tra_d = IMM_SAVE;
    vec_d = `VEC_GENERAL;
    mmu_d = 1'b0;
    refetch_d = 1'b0;
    clr_abrk = 1'b0;
    clr_dma = 1'b0;
    if (ISSUE_VALID)
    begin
      if (BRK_PRE & brk_ok)
      begin
        take_d = 1'b1;
        code_d = `EC_BREAK;
        spc_d = slot_pc;
      end
      else if (f_ae | f_miss | f_inv | f_prot)
      begin
        take_d = 1'b1;
        spc_d = FETCH_ADDR;
        tea_d = FETCH_ADDR;
        mmu_d = ~f_ae;
        if (f_ae)
          code_d = `EC_ADDR_RD;
        else if (f_miss)
        begin
          code_d = `EC_TLB_RD;
          vec_d = `VEC_TLB_MISS;
        end
        else if (f_inv)
          code_d = `EC_TLB_RD;
        else
          code_d = `EC_PROT_RD;
      end
      else if (ISSUE_IN_SLOT & (undef | priv_fault | ISSUE_PC_WRITE))
      begin
        take_d = 1'b1;
        code_d = `EC_ILL_SLOT;
        spc_d = ISSUE_BRANCH_PC;
      end
      else if (~ISSUE_IN_SLOT & (undef | priv_fault))
      begin
        take_d = 1'b1;
        code_d = `EC_ILL_GEN;
        spc_d = ISSUE_PC;
      end
      else if (d_ae | d_miss | d_inv | d_prot | d_clean)
      begin
        take_d = 1'b1;
        spc_d = slot_pc;
        tea_d = DATA_ADDR;
        mmu_d = ~d_ae;
        if (d_ae)
          code_d = rw_code(DATA_WRITE, `EC_ADDR_RD, `EC_ADDR_WR);
        else if (d_miss)
        begin
          code_d = rw_code(DATA_WRITE, `EC_TLB_RD, `EC_TLB_WR);
          vec_d = `VEC_TLB_MISS;
        end
        else if (d_inv)
          code_d = rw_code(DATA_WRITE, `EC_TLB_RD, `EC_TLB_WR);
        else if (d_prot)
          code_d = rw_code(DATA_WRITE, `EC_PROT_RD, `EC_PROT_WR);
        else
          code_d = `EC_INIT_WR;
      end
      else if (ISSUE_TRAP)
      begin
        take_d = 1'b1;
        code_d = `EC_TRAP;
        spc_d = ISSUE_NEXT_PC;
        tra_d = {`TRA_HI_ZERO, ISSUE_IMM8, `TRA_LO_ZERO};
      end
      else if (BRK_OPERAND & brk_ok)
      begin
        take_d = 1'b1;
        code_d = `EC_BREAK;
        spc_d = ISSUE_IN_SLOT ? ISSUE_BRANCH_PC : ISSUE_NEXT_PC;
      end
      else if (abrk_q & brk_ok)
      begin
        // Taken at the boundary before this instruction runs, so its own address resumes
        take_d = 1'b1;
        code_d = `EC_BREAK;
        spc_d = slot_pc;
        clr_abrk = 1'b1;
      end
      else if (dma_q & ~data_bl)
      begin
        take_d = 1'b1;
        code_d = `EC_DMA;
        spc_d = slot_pc;
        clr_dma = 1'b1;
      end
      else if (ISSUE_SR_LOAD & ISSUE_SR_CHANGE)
        refetch_d = 1'b1;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
    begin
      EXC_TAKEN <= 1'b1;
      EXC_TARGET <= `RESET_VECTOR;
      EVENT_CODE <= `EC_POWERON;
      SAVED_PC <= `ZERO32;
      FAULT_ADDR <= `ZERO32;
      IMM_SAVE <= `ZERO32;
      MMU_UPDATE <= 1'b0;
      REFETCH <= 1'b0;
      PERIPH_INIT <= 1'b1;
      rte_q <= 1'b0;
      abrk_q <= 1'b0;
      dma_q <= 1'b0;
    end
    else if (MRST_REQ)
    begin
      EXC_TAKEN <= 1'b1;
      EXC_TARGET <= `RESET_VECTOR;
      EVENT_CODE <= `EC_MANUAL;
      MMU_UPDATE <= 1'b0;
      REFETCH <= 1'b0;
      PERIPH_INIT <= 1'b1;
      rte_q <= 1'b0;
      abrk_q <= 1'b0;
      dma_q <= 1'b0;
    end
    else
    begin
      EXC_TAKEN <= take_d;
      EXC_TARGET <= take_d ? VECTOR_BASE + vec_d : EXC_TARGET;
      EVENT_CODE <= code_d;
      SAVED_PC <= spc_d;
      FAULT_ADDR <= tea_d;
      IMM_SAVE <= tra_d;
      MMU_UPDATE <= mmu_d;
      REFETCH <= refetch_d;
      PERIPH_INIT <= 1'b0;
      if (ISSUE_VALID)
        rte_q <= ISSUE_RTE & ~take_d;
      // A new request in the clearing cycle keeps its flag set
      abrk_q <= (abrk_q & ~clr_abrk) | (BRK_ASYNC & ~STATUS_BL);
      dma_q <= (dma_q & ~clr_dma) | DMA_ADDR_ERR;
    end
  end

endmodule // crex_exception_unit
`default_nettype wire

// ===== testbench/crex_dma_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Transfer engine stand-in
// ****************************************
module crex_dma_model (
  input wire logic clk,
  input wire logic go,
  input wire logic [31:0] addr,
  input wire logic [1:0] size,
  output logic err
);
  // Byte transfers can never be misaligned, so they never flag
  always @(posedge clk)
    err <= go && ((size == 2'h1 && addr[0]) || (size == 2'h2 && addr[1:0] != 2'h0));
endmodule // crex_dma_model
`default_nettype wire

// ===== testbench/crex_exc_props.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Redirect checks
// ****************************************
module crex_exc_props (
  input wire logic CLK_SYS,
  input wire logic NRST,
  input wire logic MRST_REQ,
  input wire logic ISSUE_VALID,
  input wire logic [31:0] VECTOR_BASE,
  input wire logic EXC_TAKEN,
  input wire logic [31:0] EXC_TARGET,
  input wire logic [11:0] EVENT_CODE,
  input wire logic [31:0] SAVED_PC,
  input wire logic [31:0] IMM_SAVE,
  input wire logic MMU_UPDATE,
  input wire logic PERIPH_INIT
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!NRST);
  sequence s_redir(c);
    EXC_TAKEN && EVENT_CODE == c;
  endsequence
  property p_mrst;
    MRST_REQ |=> s_redir(12'h020) ##0 (EXC_TARGET == 32'ha0000000 && PERIPH_INIT);
  endproperty
  property p_init;
    PERIPH_INIT |-> EXC_TAKEN && EXC_TARGET == 32'ha0000000;
  endproperty
  property p_miss;
    EXC_TAKEN && EXC_TARGET == VECTOR_BASE + 32'h400 |-> EVENT_CODE inside {12'h040, 12'h060};
  endproperty
  property p_gen;
    EXC_TAKEN && !(EVENT_CODE inside {12'h000, 12'h020, 12'h040, 12'h060}) |-> EXC_TARGET == VECTOR_BASE + 32'h100;
  endproperty
  property p_mmu;
    MMU_UPDATE |-> EXC_TAKEN && EVENT_CODE inside {12'h040, 12'h060, 12'h080, 12'h0a0, 12'h0c0};
  endproperty
  property p_idle;
    !ISSUE_VALID && !MRST_REQ |=> !EXC_TAKEN;
  endproperty
  property p_trap;
    s_redir(12'h160) |-> IMM_SAVE[31:10] == 22'h0 && IMM_SAVE[1:0] == 2'h0;
  endproperty
  property p_hold;
    !$stable(EVENT_CODE) || !$stable(SAVED_PC) |-> EXC_TAKEN;
  endproperty
  a_mrst: assert property (p_mrst) else $error("manual reset redirect wrong");
  a_init: assert property (p_init) else $error("init without reset redirect");
  a_miss: assert property (p_miss) else $error("miss vector with wrong code");
  a_gen: assert property (p_gen) else $error("general vector wrong");
  a_mmu: assert property (p_mmu) else $error("translation update out of place");
  a_idle: assert property (p_idle) else $error("redirect with nothing issued");
  a_trap: assert property (p_trap) else $error("trap immediate misplaced");
  a_hold: assert property (p_hold) else $error("record changed without redirect");
endmodule // crex_exc_props
bind crex_exception_unit crex_exc_props u_props (.CLK_SYS, .NRST, .MRST_REQ, .ISSUE_VALID, .VECTOR_BASE,
  .EXC_TAKEN, .EXC_TARGET, .EVENT_CODE, .SAVED_PC, .IMM_SAVE, .MMU_UPDATE, .PERIPH_INIT);
`default_nettype wire

// ===== testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Exception unit bench
// ****************************************
module tb;
  typedef struct packed {logic [31:0] a; logic [1:0] sz; logic wr, md, en; logic [3:0] t; logic [11:0] ec, off;} crex_row_t;
  localparam logic [31:0] VB = 32'h8c000000;
  localparam logic [31:0] P = 32'h00004000;
  logic CLK_SYS = 1'b0, NRST = 1'b0, MRST_REQ = 1'b0, STATUS_MD = 1'b1, MMU_EN = 1'b0, ISSUE_VALID = 1'b0;
  logic dgo = 1'b0, STATUS_BL = 1'b0, SAVED_MD = 1'b1, DMA_ADDR_ERR, EXC_TAKEN, MMU_UPDATE, REFETCH, PERIPH_INIT;
  logic [31:0] ISSUE_PC = P, FETCH_ADDR = P, DATA_ADDR = 32'h0, EXC_TARGET, SAVED_PC, FAULT_ADDR, IMM_SAVE;
  logic [15:0] ISSUE_OP = 16'h0009;
  logic [1:0] DATA_SIZE = 2'h0;
  logic [11:0] EVENT_CODE;
  logic [23:0] f = 24'h0;
  int n_mismatch = 0, compares = 0, k;
  int pb [5] = '{1, 2, 4, 5, 6};
  crex_row_t r;
  crex_row_t rows [12] = '{
    '{32'h1001, 2'h1, 1'b0, 1'b1, 1'b0, 4'h0, 12'h0e0, 12'h100}, '{32'h1002, 2'h2, 1'b1, 1'b1, 1'b0, 4'h0, 12'h1e0, 12'h100},
    '{32'h80000000, 2'h0, 1'b0, 1'b0, 1'b0, 4'h0, 12'h0e0, 12'h100}, '{32'h2000, 2'h2, 1'b0, 1'b1, 1'b1, 4'h1, 12'h040, 12'h400},
    '{32'h2000, 2'h2, 1'b1, 1'b1, 1'b1, 4'h1, 12'h060, 12'h400}, '{32'h2000, 2'h2, 1'b0, 1'b1, 1'b1, 4'h2, 12'h040, 12'h100},
    '{32'h2000, 2'h2, 1'b1, 1'b1, 1'b1, 4'h2, 12'h060, 12'h100}, '{32'h2000, 2'h2, 1'b0, 1'b1, 1'b1, 4'h4, 12'h0a0, 12'h100},
    '{32'h2000, 2'h2, 1'b1, 1'b1, 1'b1, 4'h4, 12'h0c0, 12'h100}, '{32'h2000, 2'h2, 1'b1, 1'b1, 1'b1, 4'h8, 12'h080, 12'h100},
    '{32'h2001, 2'h1, 1'b0, 1'b1, 1'b1, 4'h1, 12'h0e0, 12'h100}, '{32'h2000, 2'h2, 1'b1, 1'b1, 1'b1, 4'hc, 12'h0c0, 12'h100}};
  crex_dma_model u_dma (.clk(CLK_SYS), .go(dgo), .addr(32'h5001), .size(2'h1), .err(DMA_ADDR_ERR));
  crex_exception_unit dut (.CLK_SYS, .NRST, .MRST_REQ, .VECTOR_BASE(VB), .STATUS_MD, .STATUS_BL,
    .SAVED_MD, .SAVED_BL(1'b0), .MMU_EN, .ISSUE_VALID, .ISSUE_PC, .ISSUE_NEXT_PC(ISSUE_PC + 32'h2),
    .ISSUE_BRANCH_PC(ISSUE_PC - 32'h2), .ISSUE_IN_SLOT(f[0]), .ISSUE_OP, .ISSUE_UNDEF(f[1]), .ISSUE_CTRL_LS(f[2]),
    .ISSUE_GLOBAL_BASE(f[3]), .ISSUE_RTE(f[4]), .ISSUE_TBL_LOAD(f[5]), .ISSUE_SLEEP(f[6]), .ISSUE_PC_WRITE(f[7]),
    .ISSUE_TRAP(f[8]), .ISSUE_IMM8(8'hff), .ISSUE_SR_LOAD(f[9]), .ISSUE_SR_CHANGE(f[10]), .FETCH_VALID(f[11]),
    .FETCH_ADDR, .FETCH_TLB_MISS(f[12]), .FETCH_TLB_INVALID(f[13]), .FETCH_TLB_PROT(f[14]), .DATA_VALID(f[15]),
    .DATA_ADDR, .DATA_WRITE(f[16]), .DATA_SIZE, .DATA_TLB_MISS(f[17]), .DATA_TLB_INVALID(f[18]),
    .DATA_TLB_PROT(f[19]), .DATA_TLB_CLEAN(f[20]), .BRK_PRE(f[21]), .BRK_OPERAND(f[22]), .BRK_ASYNC(f[23]),
    .DMA_ADDR_ERR, .EXC_TAKEN, .EXC_TARGET, .EVENT_CODE, .SAVED_PC, .FAULT_ADDR, .IMM_SAVE, .MMU_UPDATE,
    .REFETCH, .PERIPH_INIT);
  always #20 CLK_SYS = ~CLK_SYS;
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wrap_up;
    if (n_mismatch == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // One idle cycle before each issue keeps the valid strobe from toggling twice in a step
  task automatic go(input logic [31:0] pc);
    @(posedge CLK_SYS);
    #1;
    ISSUE_PC = pc;
    ISSUE_VALID = 1'b1;
    @(posedge CLK_SYS);
    #1;
    ISSUE_VALID = 1'b0;
  endtask
  task automatic ex(input logic [11:0] c, input logic [11:0] o, input logic [31:0] s);
    chk(EXC_TAKEN, 1'b1);
    chk(EVENT_CODE, c);
    chk(EXC_TARGET, VB + o);
    chk(SAVED_PC, s);
  endtask
  task automatic hx(input logic [23:0] v, input logic [11:0] c, input logic [11:0] o, input logic [31:0] s);
    f = v;
    go(P);
    ex(c, o, s);
  endtask
  initial
  begin
    repeat (20) @(posedge CLK_SYS);
    chk({EXC_TAKEN, PERIPH_INIT, EVENT_CODE}, 14'h3000);
    chk(EXC_TARGET, 32'ha0000000);
    #1;
    NRST = 1'b1;
    foreach (rows[i])
    begin
      r = rows[i];
      {MMU_EN, STATUS_MD, DATA_ADDR, DATA_SIZE} = {r.en, r.md, r.a, r.sz};
      f = {3'h0, r.t, r.wr, 16'h8000};
      go(P + 32'(4 * i));
      ex(r.ec, r.off, P + 32'(4 * i));
      chk(FAULT_ADDR, r.a);
      chk(MMU_UPDATE, r.en && r.ec[7:4] != 4'he);
    end
    STATUS_MD = 1'b0;
    for (k = 0; k < 10; k++)
      hx((24'h1 << pb[k / 2]) | 24'(k % 2), k % 2 ? 12'h1a0 : 12'h180, 12'h100, k % 2 ? P - 32'h2 : P);
    f = 24'h00000c;
    go(P);
    chk(EXC_TAKEN, 1'b0);
    {STATUS_MD, ISSUE_OP} = {1'b1, 16'hf000};
    hx(24'h0, 12'h180, 12'h100, P);
    ISSUE_OP = 16'h0009;
    hx(24'h81, 12'h1a0, 12'h100, P - 32'h2);
    hx(24'h100, 12'h160, 12'h100, P + 32'h2);
    chk(IMM_SAVE, 32'h3fc);
    hx(24'h200000, 12'h1e0, 12'h100, P);
    hx(24'h400000, 12'h1e0, 12'h100, P + 32'h2);
    hx(24'h200001, 12'h1e0, 12'h100, P - 32'h2);
    FETCH_ADDR = 32'h3001;
    hx(24'h800, 12'h0e0, 12'h100, 32'h3001);
    chk(FAULT_ADDR, 32'h3001);
    FETCH_ADDR = 32'h3000;
    hx(24'h1800, 12'h040, 12'h400, 32'h3000);
    hx(24'h2800, 12'h040, 12'h100, 32'h3000);
    hx(24'h4800, 12'h0a0, 12'h100, 32'h3000);
    chk(MMU_UPDATE, 1'b1);
    // Async break is a one-cycle pulse; it must wait for the next issued instruction
    f = 24'h800000;
    @(posedge CLK_SYS);
    #1;
    hx(24'h0, 12'h1e0, 12'h100, P);
    // With the mask bit set, both break kinds are dropped for good
    {STATUS_BL, f} = {1'b1, 24'h800000};
    @(posedge CLK_SYS);
    #1;
    f = 24'h200000;
    go(P);
    chk(EXC_TAKEN, 1'b0);
    {STATUS_BL, f} = {1'b0, 24'h0};
    go(P);
    chk(EXC_TAKEN, 1'b0);
    f = 24'h10;
    go(P);
    f = 24'h200001;
    go(P);
    chk(EXC_TAKEN, 1'b0);
    SAVED_MD = 1'b0;
    f = 24'h10;
    go(P);
    hx(24'h5, 12'h1a0, 12'h100, P - 32'h2);
    SAVED_MD = 1'b1;
    f = 24'h600;
    go(P);
    chk({EXC_TAKEN, REFETCH}, 2'h1);
    {f, dgo, STATUS_BL} = {24'h0, 2'h3};
    @(posedge CLK_SYS);
    #1;
    {dgo, ISSUE_VALID, k} = {2'h1, 32'h0};
    repeat (2) @(posedge CLK_SYS);
    #1;
    chk(EXC_TAKEN, 1'b0);
    STATUS_BL = 1'b0;
    while (EXC_TAKEN !== 1'b1)
    begin
      @(posedge CLK_SYS);
      #1;
      k++;
      if (k > 8)
      begin
        n_mismatch++;
        wrap_up;
      end
    end
    ISSUE_VALID = 1'b0;
    chk(EVENT_CODE, 12'h5c0);
    chk(SAVED_PC, P);
    MRST_REQ = 1'b1;
    @(posedge CLK_SYS);
    #1;
    MRST_REQ = 1'b0;
    chk({EXC_TAKEN, PERIPH_INIT, EVENT_CODE}, 14'h3020);
    chk(EXC_TARGET, 32'ha0000000);
    chk(SAVED_PC, P);
    NRST = 1'b0;
    @(posedge CLK_SYS);
    #1;
    chk({EXC_TAKEN, PERIPH_INIT, EVENT_CODE}, 14'h3000);
    chk(SAVED_PC, 32'h0);
    NRST = 1'b1;
    @(posedge CLK_SYS);
    #1;
    chk({EXC_TAKEN, PERIPH_INIT}, 2'h0);
    wrap_up;
  end
endmodule // tb
`default_nettype wire
